// *** logic/hnmi_regs.svh ***
// Register offsets, field positions, reset values and timing for the host interrupt generator.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef HNMI_REGS_SVH
`define HNMI_REGS_SVH

// Register byte offsets (word aligned)
`define HNMI_CTRL_OFS      8'h00
`define HNMI_SOURCE_OFS    8'h04
`define HNMI_SETSRC_OFS    8'h08
`define HNMI_CMD_OFS       8'h0c
`define HNMI_STATUS_OFS    8'h10
`define HNMI_SMIEN_OFS     8'h14

// Control register fields
`define HNMI_CTRL_EN_BIT     0
`define HNMI_CTRL_LOCK_BIT   1
`define HNMI_CTRL_EMBG_BIT   2
`define HNMI_CTRL_RESET      32'h0000_0001

// Command register fields (write-one pulses)
`define HNMI_CMD_PULSE_BIT   0
`define HNMI_CMD_SMICLR_BIT  1

// Status register fields
`define HNMI_ST_LINE_BIT     0
`define HNMI_ST_ARMED_BIT    1
`define HNMI_ST_MGMT_BIT     2
`define HNMI_ST_EVT_BIT      3

// System-management-interrupt enable fields
`define HNMI_SMIEN_WDT_BIT   0
`define HNMI_SMIEN_EMB_BIT   1
`define HNMI_SMIEN_RESET     32'h0000_0000

// Source field width and number of trigger types
`define HNMI_NSRC            6

// Timing
`define HNMI_CLK_KHZ         125000
`define HNMI_PULSE_MS        30
`define HNMI_PULSE_MS_CNT    (`HNMI_PULSE_MS + 1)

`endif

// *** logic/hnmi_pkg.sv ***
// Types shared by the host interrupt generator.
// Assumes hnmi_regs.svh holds all numeric constants.
`include "hnmi_regs.svh"

package hnmi_pkg;

    // One sticky bit per trigger type
    typedef struct packed {
        logic setCmd;
        logic watchdog;
        logic processor_internal_error;
        logic event_filter_table;
        logic front_panel;
        logic chassisCmd;
    } hnmi_src_t;

    // Trigger inputs from the rest of the controller
    typedef struct packed {
        logic watchdogPreNmi;
        logic watchdogPreMgmt;
        logic processorIntErr;
        logic filterDiagAction;
        logic eventMsgArrived;
        logic frontPanelButton;
    } hnmi_trig_t;

    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hsel;
        logic        hready;
    } hnmi_ahb_req_t;

    typedef enum logic [1:0] {
        HNMI_ARMED,
        HNMI_PULSING,
        HNMI_SPENT
    } hnmi_state_t;

endpackage

// *** logic/hnmi_generator.sv ***
// Host non-maskable interrupt pulse generator with source capture and
// system-management-interrupt generation, reached over AHB-Lite.
// Assumes trigger inputs are synchronous single-cycle pulses or levels from
// logic on the same clock, except the front-panel button, which is a pin.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "hnmi_regs.svh"

module hnmi_generator
    import hnmi_pkg::*;
#(
    parameter bit          INTERR_SUPPORTED = 1'b1,
    parameter int unsigned CLK_KHZ          = `HNMI_CLK_KHZ,
    parameter int unsigned PULSE_MS         = `HNMI_PULSE_MS_CNT
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // System events
    input  wire logic                hostResetOrPowerDown,
    input  wire logic                secureModeActive,
    input  wire hnmi_pkg::hnmi_trig_t trig,
    input  wire logic                frontPanelButtonPin,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Host side
    output logic                     hostNmi,
    output logic                     systemManagementInterrupt,
    output logic                     diagLogEvent
);
    import hnmi_pkg::*;

    localparam int unsigned TICK_DIV = CLK_KHZ;
    localparam int unsigned MS_W     = $clog2(PULSE_MS + 1);
    localparam int unsigned DIV_W    = $clog2(TICK_DIV);

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    logic        wrPend_q;
    logic        rdPend_q;
    logic [7:0]  addr_q;

    wire accept = hsel && hready && htrans[1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q   <= 8'h00;
        end else begin
            wrPend_q <= accept && hwrite;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire wrCtrl   = wrPend_q && hit(addr_q, `HNMI_CTRL_OFS);
    wire wrSetSrc = wrPend_q && hit(addr_q, `HNMI_SETSRC_OFS);
    wire wrCmd    = wrPend_q && hit(addr_q, `HNMI_CMD_OFS);
    wire wrMgmtEn = wrPend_q && hit(addr_q, `HNMI_SMIEN_OFS);
    wire rdSource = rdPend_q && hit(addr_q, `HNMI_SOURCE_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Front-panel button pin: synchroniser and press edge

    logic btnMeta_q;
    logic btnSync_q;
    logic btnLast_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            btnMeta_q <= 1'b0;
            btnSync_q <= 1'b0;
            btnLast_q <= 1'b0;
        end else begin
            btnMeta_q <= frontPanelButtonPin;
            btnSync_q <= btnMeta_q;
            btnLast_q <= btnSync_q;
        end
    end

    wire btnPress = btnSync_q && !btnLast_q;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [31:0] ctrl_q;
    logic [31:0] mgmtEn_q;

    wire genEnable  = ctrl_q[`HNMI_CTRL_EN_BIT];
    wire buttonLock = ctrl_q[`HNMI_CTRL_LOCK_BIT];
    wire embGlobal  = ctrl_q[`HNMI_CTRL_EMBG_BIT];
    // Any enable write while HNMI_SPENT rearms, even when already enabled
    wire enableReq  = wrCtrl && hwdata[`HNMI_CTRL_EN_BIT];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q   <= `HNMI_CTRL_RESET;
            mgmtEn_q <= `HNMI_SMIEN_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= {29'h0, hwdata[2:0]};
            end
            if (wrMgmtEn) begin
                mgmtEn_q <= {30'h0, hwdata[1:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources

    hnmi_src_t newSrc;
    assign newSrc.setCmd                   = wrSetSrc;
    assign newSrc.watchdog                 = trig.watchdogPreNmi;
    assign newSrc.processor_internal_error = INTERR_SUPPORTED && trig.processorIntErr;
    // Secure mode deliberately not consulted here; only the lock gates it
    assign newSrc.front_panel              = btnPress && !buttonLock;
    assign newSrc.event_filter_table       = trig.filterDiagAction;
    assign newSrc.chassisCmd               = wrCmd && hwdata[`HNMI_CMD_PULSE_BIT];

    // Software-registered source bits OR in through set-source data
    wire [`HNMI_NSRC-1:0] swSrc  = wrSetSrc ? hwdata[`HNMI_NSRC-1:0] : '0;
    wire [`HNMI_NSRC-1:0] setSrc = newSrc | swSrc;
    wire                  anyTrig = |newSrc;

    hnmi_src_t src_q;

    // New events win over a read-clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            src_q <= '0;
        end else if (hostResetOrPowerDown) begin
            src_q <= '0;
        end else begin
            src_q <= (rdSource ? '0 : src_q) | setSrc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and one-shot pulse

    logic [DIV_W-1:0] div_q;
    logic             msTick;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
        end else if (div_q == DIV_W'(TICK_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign msTick = (div_q == DIV_W'(TICK_DIV - 1));

    hnmi_state_t      state_q;
    logic [MS_W-1:0]  ms_q;
    logic             logEvt_q;

    // One extra tick covers the partial first millisecond
    wire pulseDone = msTick && (ms_q == MS_W'(PULSE_MS - 1));
    wire fire      = anyTrig && genEnable;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q  <= HNMI_ARMED;
            ms_q     <= '0;
            logEvt_q <= 1'b0;
        end else begin
            logEvt_q <= 1'b0;
            unique case (state_q)
                HNMI_ARMED: begin
                    if (fire) begin
                        state_q  <= HNMI_PULSING;
                        ms_q     <= '0;
                        logEvt_q <= !newSrc.chassisCmd;
                    end
                end
                HNMI_PULSING: begin
                    if (pulseDone) begin
                        state_q <= HNMI_SPENT;
                    end else if (msTick) begin
                        ms_q <= ms_q + 1'b1;
                    end
                end
                HNMI_SPENT: begin
                    if (hostResetOrPowerDown || enableReq) begin
                        state_q <= HNMI_ARMED;
                    end
                end
            endcase
        end
    end

    assign hostNmi      = (state_q == HNMI_PULSING);
    assign diagLogEvent = logEvt_q;

    ////////////////////////////////////////////////////////////////////////////
    // System management interrupt

    logic mgmtInt_q;
    wire  mgmtSet = (trig.watchdogPreMgmt && mgmtEn_q[`HNMI_SMIEN_WDT_BIT])
                  || (trig.eventMsgArrived && embGlobal && mgmtEn_q[`HNMI_SMIEN_EMB_BIT]);
    wire  mgmtClr = (wrCmd && hwdata[`HNMI_CMD_SMICLR_BIT]) || hostResetOrPowerDown;

    // Set wins over a clear in the same cycle so no cause is lost
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mgmtInt_q <= 1'b0;
        end else begin
            mgmtInt_q <= mgmtSet || (mgmtInt_q && !mgmtClr);
        end
    end

    assign systemManagementInterrupt = mgmtInt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (addr_q)
            `HNMI_CTRL_OFS:   rdMux = ctrl_q;
            `HNMI_SOURCE_OFS: rdMux = {26'h0, src_q};
            `HNMI_SMIEN_OFS:  rdMux = mgmtEn_q;
            `HNMI_STATUS_OFS: rdMux = {28'h0, logEvt_q, mgmtInt_q, (state_q == HNMI_ARMED), hostNmi};
            default:          rdMux = 32'h0000_0000;
        endcase
    end

    assign hrdata = rdPend_q ? rdMux : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_fire;
        state_q == HNMI_ARMED && fire;
    endsequence

    a_pulse_start: assert property (@(posedge clock) disable iff (!rstn)
        s_fire |=> hostNmi) else $error("Trigger did not start pulse");

    a_pulse_min_width: assert property (@(posedge clock) disable iff (!rstn)
        $rose(hostNmi) |-> hostNmi [*8]) else $error("Pulse too short");

    a_one_shot_hold: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_SPENT && !hostResetOrPowerDown && !enableReq) |=> !hostNmi)
        else $error("Second pulse without rearm");

    a_rearm_enable: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_SPENT && enableReq) |=> state_q == HNMI_ARMED) else $error("Enable did not rearm");

    a_read_clears: assert property (@(posedge clock) disable iff (!rstn)
        (rdSource && !anyTrig && !wrSetSrc) |=> src_q == '0) else $error("Source read did not clear");

    a_chassis_nolog: assert property (@(posedge clock) disable iff (!rstn)
        (s_fire and newSrc.chassisCmd) |=> !diagLogEvent) else $error("Chassis pulse logged");

    a_disabled_quiet: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_ARMED && !genEnable) |=> !hostNmi) else $error("Pulse while disabled");

    a_mgmt_gated: assert property (@(posedge clock) disable iff (!rstn)
        (!mgmtInt_q && !mgmtSet) |=> !mgmtInt_q) else $error("Management interrupt without enabled cause");

    a_mgmt_watchdog: assert property (@(posedge clock) disable iff (!rstn)
        (trig.watchdogPreMgmt && mgmtEn_q[`HNMI_SMIEN_WDT_BIT]) |=> mgmtInt_q)
        else $error("Watchdog management interrupt missing");

    a_mgmt_message: assert property (@(posedge clock) disable iff (!rstn)
        (trig.eventMsgArrived && embGlobal && mgmtEn_q[`HNMI_SMIEN_EMB_BIT]) |=> mgmtInt_q)
        else $error("Message management interrupt missing");

    a_mgmt_clear: assert property (@(posedge clock) disable iff (!rstn)
        (mgmtClr && !mgmtSet) |=> !mgmtInt_q) else $error("Management interrupt not cleared");

    a_src_sticky: assert property (@(posedge clock) disable iff (!rstn)
        (|src_q && !rdSource && !hostResetOrPowerDown) |=> (src_q & $past(src_q)) == $past(src_q))
        else $error("Source bit lost");

    a_src_capture: assert property (@(posedge clock) disable iff (!rstn)
        (|setSrc && !hostResetOrPowerDown) |=> (src_q & $past(setSrc)) == $past(setSrc))
        else $error("Trigger source not captured");

    a_src_host_reset: assert property (@(posedge clock) disable iff (!rstn)
        hostResetOrPowerDown |=> src_q == '0) else $error("Host reset left sources set");

    a_setsrc_fires: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_ARMED && genEnable && wrSetSrc && !hostResetOrPowerDown) |=> (hostNmi && src_q.setCmd))
        else $error("Set-source write did not fire");

    a_button_fires: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_ARMED && genEnable && btnPress && !buttonLock) |=> hostNmi)
        else $error("Button press did not fire");

    a_log_pulse: assert property (@(posedge clock) disable iff (!rstn)
        (s_fire and !newSrc.chassisCmd) |=> diagLogEvent) else $error("Pulse start not logged");

    a_log_single: assert property (@(posedge clock) disable iff (!rstn)
        diagLogEvent |=> !diagLogEvent) else $error("Log event longer than one cycle");

    a_rearm_host: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == HNMI_SPENT && hostResetOrPowerDown) |=> state_q == HNMI_ARMED)
        else $error("Host reset did not rearm");

    // Width helper counts clocks apart from ms_q, so a wrong tick count shows
    localparam int unsigned PULSE_MIN = `HNMI_PULSE_MS * CLK_KHZ;
    int unsigned            nmiHigh_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nmiHigh_q <= '0;
        end else if (hostNmi) begin
            nmiHigh_q <= nmiHigh_q + 1'b1;
        end else begin
            nmiHigh_q <= '0;
        end
    end

    sequence s_pulse_end;
        $fell(hostNmi);
    endsequence

    a_pulse_full_width: assert property (@(posedge clock) disable iff (!rstn)
        s_pulse_end |-> nmiHigh_q >= PULSE_MIN) else $error("Pulse shorter than minimum width");

    a_spent_after: assert property (@(posedge clock) disable iff (!rstn)
        s_pulse_end |-> state_q == HNMI_SPENT) else $error("Pulse ended without disarming");

    a_tick_gap: assert property (@(posedge clock) disable iff (!rstn)
        msTick |=> !msTick) else $error("Millisecond tick on consecutive clocks");

endmodule // hnmi_generator

// *** bench/hnmi_host_model.sv ***
// Host processor and chipset side: watches the interrupt line.
// Assumes hostNmi is a level launched from the same clock.
`timescale 1ns/1ps

module hnmi_host_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Interrupt line
    input  wire logic hostNmi,
    // Pulse statistics: pulse count, and last width in clocks
    output int        pulseCount,
    output int        lastWidth
);
    int run;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run <= 0;
            pulseCount <= 0;
            lastWidth <= 0;
        end else if (hostNmi === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            // Counted at the fall so a stuck line never counts
            lastWidth <= run;
            pulseCount <= pulseCount + 1;
            run <= 0;
        end
    end
endmodule // hnmi_host_model

// *** bench/host_nmi_smi_generator_tb.sv ***
// Self-checking bench for the host interrupt generator.
// Assumes a millisecond tick of 10 clocks; bus waits follow hready.
`timescale 1ns/1ps
`include "hnmi_regs.svh"

module host_nmi_smi_generator_tb;
    import hnmi_pkg::*;
    localparam int MSK = 10;
    logic        clock, rstn, hostRst, secure, panelPin, hsel, hwrite, hready;
    logic        hreadyout, hresp, hostNmi, sysMgmtInt, logEv;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    hnmi_trig_t  trig;
    int          pulseCount, lastWidth;
    int          logCount = 0;
    int          err_count = 0;
    int          n_tests = 0;
    logic [31:0] d;
    assign hready = hreadyout;

    hnmi_generator #(.CLK_KHZ(MSK)) dut (.clock(clock), .rstn(rstn), .hostResetOrPowerDown(hostRst),
        .secureModeActive(secure), .trig(trig), .frontPanelButtonPin(panelPin), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hostNmi(hostNmi), .systemManagementInterrupt(sysMgmtInt), .diagLogEvent(logEv));
    hnmi_host_model host (.clock(clock), .rstn(rstn), .hostNmi(hostNmi),
        .pulseCount(pulseCount), .lastWidth(lastWidth));

    always @(posedge clock) if (logEv === 1'b1) logCount++;
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        // Each phase holds until hready is seen high at a rising edge
        do begin @(posedge clock); end while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge clock); end while (hready !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask
    // Trigger codes: 20 nmi-watchdog, 10 sysmgmt-watchdog, 08 cpu error, 04 filter, 02 msg
    task automatic fire(input logic [5:0] t);
        @(posedge clock);
        trig <= hnmi_trig_t'(t);
        @(posedge clock);
        trig <= '0;
        @(negedge clock);
    endtask
    task automatic press();
        @(posedge clock);
        panelPin <= 1'b1;
        repeat (6) @(posedge clock);
        panelPin <= 1'b0;
    endtask
    // Bounded so an absent pulse is judged after a full width has passed
    task automatic expect_pulse(input string nm, input logic yes);
        int c0;
        c0 = pulseCount;
        for (int i = 0; i < 40 * MSK && pulseCount == c0; i++) @(posedge clock);
        chk(nm, {31'h0, yes}, pulseCount - c0);
        if (yes) chk("width", 32'h1, {31'h0, lastWidth >= 30 * MSK});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk("ctrl", `HNMI_CTRL_OFS, `HNMI_CTRL_RESET);
        rchk("sysmgmt enables", `HNMI_SMIEN_OFS, `HNMI_SMIEN_RESET);
        rchk("unmapped", 8'h40, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_chassis();
        int c0;
        c0 = logCount;
        wr(`HNMI_CMD_OFS, 32'h1);
        bus(1'b0, `HNMI_STATUS_OFS, 32'h0, d);
        chk("line state", 32'h1, {31'h0, d[0]});
        expect_pulse("chassis", 1'b1);
        chk("chassis log", 32'h0, logCount - c0);
        rchk("source", `HNMI_SOURCE_OFS, 32'h01);
        rchk("source cleared", `HNMI_SOURCE_OFS, 32'h0);
        $display("t_chassis done");
    endtask
    task automatic t_oneshot();
        int c0;
        fire(6'h08);
        expect_pulse("spent", 1'b0);
        rchk("source cpu", `HNMI_SOURCE_OFS, 32'h08);
        wr(`HNMI_CTRL_OFS, 32'h1);
        secure <= 1'b1;
        c0 = logCount;
        press();
        expect_pulse("button", 1'b1);
        chk("button log", 32'h1, logCount - c0);
        secure <= 1'b0;
        rchk("source button", `HNMI_SOURCE_OFS, 32'h02);
        wr(`HNMI_CTRL_OFS, 32'h3);
        press();
        expect_pulse("locked", 1'b0);
        wr(`HNMI_CTRL_OFS, 32'h1);
        bus(1'b0, `HNMI_SOURCE_OFS, 32'h0, d);
        $display("t_oneshot done");
    endtask
    task automatic t_disable();
        wr(`HNMI_CTRL_OFS, 32'h0);
        fire(6'h04);
        expect_pulse("disabled", 1'b0);
        wr(`HNMI_CTRL_OFS, 32'h1);
        fire(6'h20);
        expect_pulse("watchdog", 1'b1);
        rchk("source acc", `HNMI_SOURCE_OFS, 32'h14);
        @(posedge clock);
        hostRst <= 1'b1;
        @(posedge clock);
        hostRst <= 1'b0;
        wr(`HNMI_SETSRC_OFS, 32'h04);
        expect_pulse("setsrc", 1'b1);
        rchk("source set", `HNMI_SOURCE_OFS, 32'h24);
        $display("t_disable done");
    endtask
    task automatic t_sysmgmt();
        wr(`HNMI_CTRL_OFS, 32'h5);
        fire(6'h10);
        fire(6'h02);
        chk("sm disabled", 32'h0, {31'h0, sysMgmtInt});
        wr(`HNMI_SMIEN_OFS, 32'h1);
        fire(6'h10);
        chk("sm watchdog", 32'h1, {31'h0, sysMgmtInt});
        wr(`HNMI_CMD_OFS, 32'h2);
        @(negedge clock);
        chk("sm cleared", 32'h0, {31'h0, sysMgmtInt});
        wr(`HNMI_SMIEN_OFS, 32'h2);
        fire(6'h10);
        chk("sm wdt masked", 32'h0, {31'h0, sysMgmtInt});
        fire(6'h02);
        chk("sm message", 32'h1, {31'h0, sysMgmtInt});
        wr(`HNMI_CMD_OFS, 32'h2);
        wr(`HNMI_CTRL_OFS, 32'h1);
        fire(6'h02);
        chk("sm global off", 32'h0, {31'h0, sysMgmtInt});
        $display("t_sysmgmt done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        err_count++;
        results();
    end
    initial begin
        rstn = 1'b0;
        hostRst = 1'b0;
        secure = 1'b0;
        panelPin = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        trig = '0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_chassis();
        t_oneshot();
        t_disable();
        t_sysmgmt();
        results();
    end
endmodule // host_nmi_smi_generator_tb
